// ---- src/rsr_regs.sv ----
/*
  Signal strength, test and FIFO status registers of the reader front end.
  Assumes the host port delivers one-cycle read and write strobes with an
  address and write data, and that the receive, transmit and FIFO activity
  signals come from the framing logic on the same clock.
*/
`timescale 1ns/1ps
module rsr_regs
  import rsr_pkg::*;
#(
  parameter logic [12:0] settle_cycles = rsr_osc_cycles
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire rsr_host_t  host,
  output logic [7:0]      rdata,
  output logic            rvalid,
  input  wire logic       osc_running,
  input  wire logic       channel_swap,
  input  wire logic [2:0] receive_input_one,
  input  wire logic [2:0] receive_input_two,
  input  wire logic [2:0] gain_level,
  input  wire logic       rf_measure_busy,
  input  wire logic       rx_active,
  input  wire logic       tx_start,
  input  wire logic       tx_active,
  input  wire logic       fifo_push,
  input  wire logic       fifo_pop,
  input  wire logic       stop_condition,
  input  wire logic       keying_pin,
  input  wire logic       modpin_in,
  input  wire logic       rx_subcarrier,
  input  wire logic       framer_subcarrier,
  output logic            keying_pin_decoder_input,
  output logic            decoder_input,
  output logic            modpin_subcarrier_out,
  output logic            modpin_out_en,
  output logic            modpin_direct_tx,
  output logic            receiver_reset,
  output rsr_ctrl_t       ctrl,
  output logic            fifo_irq_event
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] analog;
    logic [7:0] digital;
    logic [2:0] main_peak;
    logic [2:0] aux_peak;
    logic [4:0] fifo_count;
    logic       fifo_high_flag;
    logic       fifo_low_flag;
    logic       fifo_ovf_flag;
    logic [7:0] rdata;
    logic       rvalid;
    logic       fifo_irq;
    logic       subc_out;
    logic       dec_in;
  } rsr_state_t;

  rsr_state_t st;
  rsr_state_t next_st;
  logic       osc_stable;
  logic [2:0] main_src;
  logic [2:0] aux_src;
  logic [2:0] main_view;
  logic [7:0] strength_word;
  logic [7:0] fifo_word;
  logic       wr_analog;
  logic       wr_digital;
  logic       tx_fifo_low;
  logic       rx_fifo_high;
  logic       push_ok;

  rsr_osc_timer #(
    .settle_cycles (settle_cycles)
  ) u_osc (
    .clock       (clock),
    .rst_n       (rst_n),
    .osc_running (osc_running),
    .osc_stable  (osc_stable)
  );

  // ==========================================================
  // Combinational views
  always_comb begin
    aux_src = channel_swap ? receive_input_one : receive_input_two;
    main_src = receive_input_one;
    main_view = st.analog[rsr_sel_agc_view] ? gain_level : st.main_peak;
    strength_word = 8'h00;
    strength_word[rsr_osc_ok_bit] = osc_stable;
    strength_word[rsr_aux_lsb +: 3] = st.aux_peak;
    strength_word[2:0] = main_view;
    fifo_word = 8'h00;
    fifo_word[rsr_fifo_high_bit] = st.fifo_high_flag;
    fifo_word[rsr_fifo_low_bit] = st.fifo_low_flag;
    fifo_word[rsr_fifo_ovf_bit] = st.fifo_ovf_flag;
    // Empty FIFO also reads 0, the same as one byte; no flag tells the two apart
    fifo_word[3:0] = (st.fifo_count == 5'h00) ? 4'h0 : 4'(st.fifo_count - 5'h01);
    wr_analog = host.wr && host.addr == rsr_addr_analog;
    wr_digital = host.wr && host.addr == rsr_addr_digital;
    push_ok = fifo_push && (st.fifo_count < rsr_fifo_depth || fifo_pop);
    rx_fifo_high = rx_active && st.fifo_count >= rsr_fifo_high_lvl;
    tx_fifo_low = tx_active && st.fifo_count <= rsr_fifo_low_lvl;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.rvalid = host.rd;
    next_st.rdata = 8'h00;
    if (host.rd) begin
      case (host.addr)
        rsr_addr_strength: next_st.rdata = strength_word;
        rsr_addr_analog:   next_st.rdata = st.analog;
        rsr_addr_digital:  next_st.rdata = st.digital;
        rsr_addr_fifo:     next_st.rdata = fifo_word;
        default:           next_st.rdata = 8'h00;
      endcase
    end
    // Status registers take no write decode at all
    if (wr_analog) begin
      next_st.analog = host.wdata;
    end
    if (wr_digital) begin
      next_st.digital = host.wdata;
    end
    // Stop condition ends test mode; a same-cycle write loses to it on purpose
    if (stop_condition) begin
      next_st.digital[rsr_dig_dec] = 1'b0;
      next_st.digital[rsr_dig_io_hi] = 1'b0;
      next_st.digital[rsr_dig_io_lo] = 1'b0;
    end
    // Peak hold; the RF measurement command owns the converter meanwhile
    if (tx_start) begin
      next_st.main_peak = 3'h0;
      next_st.aux_peak = 3'h0;
    end else if (rx_active && !rf_measure_busy) begin
      next_st.main_peak = rsr_peak(st.main_peak, main_src);
      next_st.aux_peak = rsr_peak(st.aux_peak, aux_src);
    end
    // FIFO occupancy
    if (push_ok && !(fifo_pop && st.fifo_count != 5'h00)) begin
      next_st.fifo_count = st.fifo_count + 5'h01;
    end else if (!push_ok && fifo_pop && st.fifo_count != 5'h00) begin
      next_st.fifo_count = st.fifo_count - 5'h01;
    end
    next_st.fifo_high_flag = rx_fifo_high;
    next_st.fifo_low_flag = tx_fifo_low;
    // Overflow is sticky until the next transmission; set beats clear
    if (fifo_push && !push_ok) begin
      next_st.fifo_ovf_flag = 1'b1;
    end else if (tx_start) begin
      next_st.fifo_ovf_flag = 1'b0;
    end
    next_st.fifo_irq = (rx_fifo_high && !st.fifo_high_flag)
                    || (tx_fifo_low && !st.fifo_low_flag);
    next_st.subc_out = st.analog[rsr_sel_subc_out] && rx_subcarrier;
    next_st.dec_in = st.analog[rsr_sel_keying] ? keying_pin : framer_subcarrier;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.analog <= rsr_test_reset;
      st.digital <= rsr_test_reset;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign fifo_irq_event = st.fifo_irq;
  assign keying_pin_decoder_input = st.analog[rsr_sel_keying];
  assign decoder_input = st.dec_in;
  assign modpin_subcarrier_out = st.subc_out;
  assign modpin_out_en = st.analog[rsr_sel_subc_out];
  // Direct mode passes the pin through unregistered to keep modulation timing
  assign modpin_direct_tx = st.analog[rsr_sel_direct] && modpin_in;
  assign receiver_reset = st.analog[rsr_sel_direct];
  assign ctrl.decoder_from_keying = st.analog[rsr_sel_keying];
  assign ctrl.subcarrier_to_modpin = st.analog[rsr_sel_subc_out];
  assign ctrl.direct_tx_and_rx_reset = st.analog[rsr_sel_direct];
  assign ctrl.second_stage_select = st.analog[rsr_sel_stage];
  assign ctrl.second_stage_attenuate = st.analog[rsr_sel_atten2];
  assign ctrl.first_stage_attenuate = st.analog[rsr_sel_atten1];
  assign ctrl.gain_control_view = st.analog[rsr_sel_agc_view];
  assign ctrl.rf_level_check = st.digital[rsr_dig_rf_level];
  assign ctrl.coder_fast_clock = st.digital[rsr_dig_fast_clk];
  assign ctrl.test_mode = st.digital[rsr_dig_dec] | st.digital[rsr_dig_io_hi]
                        | st.digital[rsr_dig_io_lo];

  // ==========================================================
  // Checks
  peak_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    tx_start |=> (st.main_peak == 3'h0 && st.aux_peak == 3'h0))
    else $error("strength fields not cleared at transmit start");

  peak_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!tx_start && !rx_active) |=> $stable(st.main_peak) && $stable(st.aux_peak))
    else $error("held strength changed outside reception");

  rf_measure_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rf_measure_busy && !tx_start) |=> $stable(st.main_peak))
    else $error("strength tracked during amplitude measurement");

  swap_aux_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_active && !rf_measure_busy && !tx_start && channel_swap
     && receive_input_one > st.aux_peak) |=> st.aux_peak == $past(receive_input_one))
    else $error("swapped auxiliary field not following first input");

  read_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.rd && host.addr == rsr_addr_fifo) |=> rvalid && rdata[7] == 1'b0)
    else $error("FIFO status read wrong");

  status_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.wr && host.addr == rsr_addr_strength) |=> $stable(st.analog) && $stable(st.digital))
    else $error("status write disturbed a register");

  stop_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    stop_condition |=> !ctrl.test_mode)
    else $error("test mode survived stop condition");

  high_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_active && st.fifo_count >= rsr_fifo_high_lvl) |=> st.fifo_high_flag)
    else $error("FIFO high flag missing");

  low_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tx_active && st.fifo_count <= rsr_fifo_low_lvl) |=> st.fifo_low_flag)
    else $error("FIFO low flag missing");

  overflow_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fifo_push && !fifo_pop && st.fifo_count == rsr_fifo_depth) |=> st.fifo_ovf_flag)
    else $error("overflow not flagged");

  count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fifo_push && !fifo_pop && st.fifo_count < rsr_fifo_depth)
      |=> st.fifo_count == $past(st.fifo_count) + 5'h01)
    else $error("FIFO count did not step");

  agc_view_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.rd && host.addr == rsr_addr_strength && st.analog[rsr_sel_agc_view])
      |=> rdata[2:0] == $past(gain_level))
    else $error("gain level not shown");

  osc_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.rd && host.addr == rsr_addr_strength)
      |=> rdata[7] == 1'b0 && rdata[rsr_osc_ok_bit] == $past(osc_stable))
    else $error("oscillator bit misreported");

  aux_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.rd && host.addr == rsr_addr_strength) |=> rdata[5:3] == $past(st.aux_peak))
    else $error("auxiliary field misplaced");

  main_field_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.rd && host.addr == rsr_addr_strength && !st.analog[rsr_sel_agc_view])
      |=> rdata[2:0] == $past(st.main_peak))
    else $error("main field misplaced");

  main_track_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_active && !rf_measure_busy && !tx_start && receive_input_one > st.main_peak)
      |=> st.main_peak == $past(receive_input_one))
    else $error("main field not following first input");

  aux_track_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_active && !rf_measure_busy && !tx_start && !channel_swap
     && receive_input_two > st.aux_peak) |=> st.aux_peak == $past(receive_input_two))
    else $error("auxiliary field not following second input");

  peak_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_start
      |=> st.main_peak >= $past(st.main_peak) && st.aux_peak >= $past(st.aux_peak))
    else $error("held peak dropped without a transmission");

  reset_clear_a: assert property (@(posedge clock)
    $rose(rst_n) |-> st.analog == rsr_test_reset && st.digital == rsr_test_reset)
    else $error("test registers not cleared by reset");

  analog_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.wr && host.addr == rsr_addr_analog) |=> st.analog == $past(host.wdata))
    else $error("analog test write lost");

  digital_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.wr && host.addr == rsr_addr_digital && !stop_condition)
      |=> st.digital == $past(host.wdata))
    else $error("digital test write lost");

  test_enter_a: assert property (@(posedge clock) disable iff (!rst_n)
    (host.wr && host.addr == rsr_addr_digital && !stop_condition
     && host.wdata[rsr_dig_dec]) |=> ctrl.test_mode)
    else $error("decoder test bit did not enter test mode");

  keying_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    st.analog[rsr_sel_keying] |=> decoder_input == $past(keying_pin))
    else $error("keying pin not routed to decoder");

  framer_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    !st.analog[rsr_sel_keying] |=> decoder_input == $past(framer_subcarrier))
    else $error("framer subcarrier not routed to decoder");

  subc_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    st.analog[rsr_sel_subc_out] |=> modpin_subcarrier_out == $past(rx_subcarrier))
    else $error("subcarrier not driven on modulation pin");

  subc_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !st.analog[rsr_sel_subc_out] |=> !modpin_subcarrier_out)
    else $error("subcarrier driven while not selected");

  direct_mod_a: assert property (@(posedge clock) disable iff (!rst_n)
    modpin_direct_tx |-> receiver_reset && modpin_in)
    else $error("direct modulation without its enable");

  gain_ctrl_a: assert property (@(posedge clock) disable iff (!rst_n)
    {ctrl.second_stage_select, ctrl.second_stage_attenuate, ctrl.first_stage_attenuate}
      == st.analog[rsr_sel_stage:rsr_sel_atten1])
    else $error("stage controls disagree with analog test bits");

  fast_clock_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.coder_fast_clock == st.digital[rsr_dig_fast_clk]
      && ctrl.rf_level_check == st.digital[rsr_dig_rf_level])
    else $error("digital test controls disagree with register");

  irq_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    fifo_irq_event |=> !fifo_irq_event)
    else $error("FIFO level event longer than one cycle");

  irq_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    fifo_irq_event |-> st.fifo_high_flag || st.fifo_low_flag)
    else $error("FIFO level event without a level flag");

  read_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    !host.rd |=> !rvalid && rdata == 8'h00)
    else $error("read answer without a read");

  count_max_a: assert property (@(posedge clock) disable iff (!rst_n)
    st.fifo_count <= rsr_fifo_depth)
    else $error("FIFO count beyond depth");

  count_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fifo_pop && !fifo_push && st.fifo_count != 5'h00)
      |=> st.fifo_count == $past(st.fifo_count) - 5'h01)
    else $error("FIFO count did not drop");

  high_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rx_active |=> !st.fifo_high_flag)
    else $error("FIFO high flag outside reception");

  low_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_active |=> !st.fifo_low_flag)
    else $error("FIFO low flag outside transmission");

endmodule : rsr_regs

// ---- src/rsr_pkg.sv ----
/*
  Constants and carrier types for the signal strength, test and FIFO status
  register group of the HF reader front end.
  Assumes a host port that presents 5-bit register addresses with read and
  write strobes, all synchronous to the 20 MHz system clock.
*/
package rsr_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] rsr_addr_strength = 5'h0f;
  localparam logic [4:0] rsr_addr_analog   = 5'h1a;
  localparam logic [4:0] rsr_addr_digital  = 5'h1b;
  localparam logic [4:0] rsr_addr_fifo     = 5'h1c;
  localparam logic [7:0] rsr_test_reset    = 8'h00;

  // ==========================================================
  // Field positions
  localparam int rsr_osc_ok_bit    = 6;
  localparam int rsr_aux_lsb       = 3;
  localparam int rsr_sel_keying    = 7;
  localparam int rsr_sel_subc_out  = 6;
  localparam int rsr_sel_direct    = 5;
  localparam int rsr_sel_stage     = 4;
  localparam int rsr_sel_atten2    = 3;
  localparam int rsr_sel_atten1    = 2;
  localparam int rsr_sel_agc_view  = 0;
  localparam int rsr_dig_rf_level  = 7;
  localparam int rsr_dig_io_hi     = 3;
  localparam int rsr_dig_io_lo     = 2;
  localparam int rsr_dig_dec       = 1;
  localparam int rsr_dig_fast_clk  = 0;
  localparam int rsr_fifo_high_bit = 6;
  localparam int rsr_fifo_low_bit  = 5;
  localparam int rsr_fifo_ovf_bit  = 4;

  // ==========================================================
  // FIFO levels and timing
  localparam logic [4:0] rsr_fifo_depth    = 5'h0c;
  localparam logic [4:0] rsr_fifo_high_lvl = 5'h09;
  localparam logic [4:0] rsr_fifo_low_lvl  = 5'h03;
  localparam int         rsr_osc_settle_ns = 200_000;
  localparam int         rsr_clock_ns      = 50;
  localparam logic [12:0] rsr_osc_cycles   =
    13'(rsr_osc_settle_ns / rsr_clock_ns);
  localparam logic [2:0] rsr_level_top     = 3'h7;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rsr_host_t;

  typedef struct packed {
    logic       decoder_from_keying;
    logic       subcarrier_to_modpin;
    logic       direct_tx_and_rx_reset;
    logic       second_stage_select;
    logic       second_stage_attenuate;
    logic       first_stage_attenuate;
    logic       gain_control_view;
    logic       rf_level_check;
    logic       coder_fast_clock;
    logic       test_mode;
  } rsr_ctrl_t;

  typedef enum logic [1:0] {
    rsr_idle = 2'b00,
    rsr_tx   = 2'b01,
    rsr_rx   = 2'b10
  } rsr_phase_t;

  // Seven usable levels; the converter never presents more than the top code
  function automatic logic [2:0] rsr_peak(input logic [2:0] held, input logic [2:0] now);
    logic [2:0] c;
    c = (now > rsr_level_top) ? rsr_level_top : now;
    rsr_peak = (c > held) ? c : held;
  endfunction : rsr_peak

endpackage : rsr_pkg

// ---- src/rsr_osc_timer.sv ----
/*
  Oscillator settle timer: raises a ready level a fixed number of cycles
  after the oscillator reports running.
  Assumes the run input is synchronous to clock.
*/
`timescale 1ns/1ps
module rsr_osc_timer
  import rsr_pkg::*;
#(
  parameter logic [12:0] settle_cycles = rsr_osc_cycles
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic osc_running,
  output logic      osc_stable
);

  typedef struct packed {
    logic [12:0] count;
    logic        stable;
  } rsr_tmr_t;

  rsr_tmr_t st;
  rsr_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (!osc_running) begin
      next_st = '0;
    end else if (st.count >= settle_cycles - 13'h0001) begin
      next_st.stable = 1'b1;
    end else begin
      next_st.count = st.count + 13'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign osc_stable = st.stable;

  stable_late_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(osc_stable) |-> $past(osc_running, 2))
    else $error("oscillator stable raised without a running oscillator");

endmodule : rsr_osc_timer

// ---- tb/rsr_host_model.sv ----
/*
  Host microcontroller model: issues single-cycle read and write strobes on
  the register port and collects the registered read answer.
  Assumes inputs change on the falling edge of clock and the port answers
  one cycle after the taking edge.
*/
`timescale 1ns/1ps
module rsr_host_model
  import rsr_pkg::*;
(
  input  wire logic       clock,
  output rsr_host_t       host,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial host = '0;

  // ==========================================================
  // Bus cycles
  // Released address and data are inverted so stale values never match
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock);
    host = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    host = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    // The answer stands only one cycle after the taking edge, so take it mid-cycle
    @(negedge clock);
    d = rdata;
    v = rvalid;
    host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
  endtask : read_reg
endmodule : rsr_host_model

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the strength, test and FIFO status registers.
  Assumes the host model drives the register port; all other inputs are
  driven here on the falling clock edge.
*/
`timescale 1ns/1ps
module tb_top
  import rsr_pkg::*;
;
  logic clock, rst_n, osc, swap, busy, rxa, txs, txa, push, pop, stop;
  logic kp, mi, rsub, fsub, kpdi, dec, mso, moe, mdt, rrst, irq, rv;
  logic [2:0] in1, in2, gain;
  logic [7:0] rdata, d;
  rsr_host_t host;
  rsr_ctrl_t ctrl;
  int errors, checks_done, cycles, irqs;

  // ==========================================================
  // Clock, instances
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  rsr_host_model hm (.clock(clock), .host(host), .rdata(rdata), .rvalid(rv));

  // Short settle count keeps the oscillator test brief
  rsr_regs #(.settle_cycles(13'h0014)) dut (.clock(clock), .rst_n(rst_n), .host(host),
    .rdata(rdata), .rvalid(rv), .osc_running(osc), .channel_swap(swap),
    .receive_input_one(in1), .receive_input_two(in2), .gain_level(gain),
    .rf_measure_busy(busy), .rx_active(rxa), .tx_start(txs), .tx_active(txa),
    .fifo_push(push), .fifo_pop(pop), .stop_condition(stop), .keying_pin(kp),
    .modpin_in(mi), .rx_subcarrier(rsub), .framer_subcarrier(fsub),
    .keying_pin_decoder_input(kpdi), .decoder_input(dec), .modpin_subcarrier_out(mso),
    .modpin_out_en(moe), .modpin_direct_tx(mdt), .receiver_reset(rrst), .ctrl(ctrl),
    .fifo_irq_event(irq));

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic v;
    hm.read_reg(a, d, v);
    check(16'(v), 16'h0001);
    check(16'(d), 16'(exp));
  endtask : rd

  // Reads into d for a field-wise comparison by the caller
  task automatic rd_any(input logic [4:0] a);
    logic v;
    hm.read_reg(a, d, v);
    check(16'(v), 16'h0001);
  endtask : rd_any

  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(negedge clock);
      if (which == 0) push = 1'b1; else if (which == 1) pop = 1'b1;
      else if (which == 2) txs = 1'b1; else stop = 1'b1;
      @(negedge clock);
      {push, pop, txs, stop} = 4'h0;
    end
  endtask : pulse

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(5'h1a, 8'h00);
    rd(5'h1b, 8'h00);
    rd(5'h1c, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_osc();
    @(negedge clock) osc = 1'b1;
    repeat (10) @(negedge clock);
    rd(5'h0f, 8'h00);
    repeat (12) @(negedge clock);
    rd(5'h0f, 8'h40);
    $display("oscillator test done");
  endtask : t_osc

  task automatic t_peak();
    @(negedge clock) {rxa, in1, in2} = {1'b1, 3'h5, 3'h2};
    repeat (3) @(negedge clock);
    {in1, in2} = {3'h3, 3'h7};
    repeat (3) @(negedge clock);
    {rxa, in1, in2} = 7'h00;
    rd(5'h0f, 8'h7d);
    {busy, rxa, in1} = {2'b11, 3'h6};
    repeat (3) @(negedge clock);
    {busy, rxa} = 2'b00;
    rd(5'h0f, 8'h7d);
    pulse(2, 1);
    rd(5'h0f, 8'h40);
    {swap, rxa, in1, in2} = {2'b11, 3'h4, 3'h1};
    repeat (3) @(negedge clock);
    rxa = 1'b0;
    rd_any(5'h0f);
    check(16'(d[5:3]), 16'h0004);
    swap = 1'b0;
    pulse(2, 1);
    gain = 3'h6;
    hm.write_reg(5'h1a, 8'h01);
    rd_any(5'h0f);
    check(16'(d[2:0]), 16'h0006);
    hm.write_reg(5'h1a, 8'h00);
    $display("strength test done");
  endtask : t_peak

  task automatic t_ctrl();
    int idx;
    logic [7:0] b;
    {kp, mi, rsub, fsub} = 4'b1110;
    for (int i = 0; i < 8; i++) begin
      if (i == 1) continue;
      b = 8'h01 << i;
      idx = (i == 0) ? 3 : i + 2;
      hm.write_reg(5'h1a, b);
      rd(5'h1a, b);
      check(16'(ctrl), 16'h0001 << idx);
      check(16'({kpdi, dec, mso, moe, mdt, rrst}),
        16'({b[7], b[7], b[6], b[6], b[5], b[5]}));
    end
    hm.write_reg(5'h1a, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (i > 3 && i < 7) continue;
      b = 8'h01 << i;
      idx = (i == 7) ? 2 : (i == 0) ? 1 : 0;
      hm.write_reg(5'h1b, b);
      check(16'(ctrl), 16'h0001 << idx);
    end
    hm.write_reg(5'h1b, 8'h8f);
    pulse(3, 1);
    rd(5'h1b, 8'h81);
    check(16'(ctrl.test_mode), 16'h0000);
    hm.write_reg(5'h1b, 8'h00);
    $display("control test done");
  endtask : t_ctrl

  task automatic t_fifo();
    irqs = 0;
    @(negedge clock) rxa = 1'b1;
    pulse(0, 9);
    rd(5'h1c, 8'h48);
    check(16'(irqs), 16'h0001);
    pulse(0, 4);
    rd(5'h1c, 8'h5b);
    {rxa, txa} = 2'b01;
    pulse(1, 9);
    rd(5'h1c, 8'h32);
    check(16'(irqs), 16'h0002);
    pulse(2, 1);
    rd(5'h1c, 8'h22);
    hm.write_reg(5'h1c, 8'hff);
    hm.write_reg(5'h0f, 8'hff);
    hm.write_reg(5'h05, 8'hff);
    rd(5'h1c, 8'h22);
    rd(5'h0f, 8'h40);
    rd(5'h05, 8'h00);
    txa = 1'b0;
    $display("fifo test done");
  endtask : t_fifo

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, osc, swap, busy, rxa, txs, txa, push, pop, stop} = 10'h000;
    {kp, mi, rsub, fsub, in1, in2, gain} = 13'h0000;
    {errors, checks_done, cycles, irqs} = 128'h0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_osc();
    t_peak();
    t_ctrl();
    t_fifo();
    close_out();
  end
endmodule : tb_top
